//--- hw/ao_pkg.sv
// analog_output_pkg: shared constants and types for the analog output timing engine
package analog_output_pkg;

	// ------------------------------------------------------------
	// register map (byte offsets on the apb bus)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MODE = 8'h04;
	localparam logic [7:0] OFS_TRIG = 8'h08;
	localparam logic [7:0] OFS_DIV = 8'h0c;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] OFS_DELAY = 8'h14;
	localparam logic [7:0] OFS_NCHAN = 8'h18;
	localparam logic [7:0] OFS_BUFLEN = 8'h1c;
	localparam logic [7:0] OFS_TTIME = 8'h20;
	localparam logic [7:0] OFS_SPDATA = 8'h24;
	localparam logic [7:0] OFS_STATUS = 8'h28;
	localparam logic [7:0] OFS_DONE = 8'h2c;
	localparam logic [7:0] OFS_TBFREQ = 8'h30;

	// ------------------------------------------------------------
	// bit positions
	// ------------------------------------------------------------
	localparam int CTL_START = 0;
	localparam int CTL_STOP = 1;
	localparam int CTL_SWTRIG = 2;
	localparam int STS_RUN = 0;
	localparam int STS_ARMED = 1;
	localparam int STS_UNDER = 2;
	localparam int STS_LATE = 3;
	localparam int STS_CFGERR = 4;
	localparam int STS_LEVEL = 16;
	localparam int PIN_SCLK = 8;
	localparam int PIN_TB = 9;
	localparam int PIN_OS = 10;
	localparam int NPINS = 13;

	// ------------------------------------------------------------
	// reset values, sizes and rates
	// ------------------------------------------------------------
	localparam logic [31:0] MODE_RST = 32'h0000_0100;
	localparam logic [31:0] ONE_RST = 32'h0000_0001;
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TB_10M_HZ = 10_000_000;
	localparam int unsigned TB_12M8_HZ = 12_800_000;
	localparam int unsigned TB_13M1_HZ = 13_107_200;
	localparam int unsigned ONBOARD_CH_LIMIT = 16;
	localparam int ENGINES = 8;
	localparam int TERMS = 8;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] SM_FINITE = 2'h0;
	localparam logic [1:0] SM_REGEN = 2'h1;
	localparam logic [1:0] SM_ONBOARD = 2'h2;
	localparam logic [1:0] SM_NONREGEN = 2'h3;
	localparam logic [1:0] TT_SCLK = 2'h0;
	localparam logic [1:0] TT_CHDET = 2'h1;
	localparam logic [2:0] TB_INT = 3'h0;
	localparam logic [2:0] TB_EXT = 3'h1;
	localparam logic [2:0] TB_10M = 3'h2;
	localparam logic [2:0] TB_12M8 = 3'h3;
	localparam logic [2:0] TB_13M1 = 3'h4;
	localparam logic [2:0] SS_NONE = 3'h0;
	localparam logic [2:0] SS_SW = 3'h1;
	localparam logic [2:0] SS_TERM = 3'h2;
	localparam logic [2:0] SS_AIREF = 3'h3;
	localparam logic [2:0] SS_AISTART = 3'h4;
	localparam logic [2:0] SS_TIME = 3'h5;
	localparam logic [2:0] SS_INTERNAL = 3'h6;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ARMED = 5'h02,
		ST_DELAY = 5'h04,
		ST_RUN = 5'h08,
		ST_LOAD = 5'h10
	} eng_state_t;

	typedef struct packed {
		logic [17:0] rsv;
		logic sclk_route;
		logic [2:0] sclk_term;
		logic sclk_pol;
		logic [2:0] tb_sel;
		logic ext_sclk;
		logic [1:0] timing;
		logic hw_timed_single_point_mode;
		logic [1:0] smode;
	} mode_t;

	typedef struct packed {
		logic [14:0] rsv;
		logic pause_low;
		logic pause_analog;
		logic [2:0] pause_term;
		logic pause_en;
		logic start_route;
		logic [2:0] start_oterm;
		logic [2:0] start_term;
		logic start_fall;
		logic [2:0] start_src;
	} trig_t;

endpackage : analog_output_pkg

//--- hw/pin_sync.sv
// pin_sync: two-flop synchroniser for a bundle of asynchronous pins
module pin_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	// first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end

	assign q = s2_q;
endmodule : pin_sync

//--- hw/sample_fifo.sv
// sample_fifo: onboard sample fifo between host transfers and output modules
module sample_fifo #(
	parameter int W = 32,
	parameter int DEPTH = 64
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic push,
	input wire logic [W-1:0] din,
	input wire logic pop,
	output logic [W-1:0] dout,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (2 ** AW) != DEPTH) begin : g_bad_depth
		$error("sample_fifo depth must be a power of two");
	end

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [AW:0] lv_q, lv_d;
	logic do_push, do_pop;

	// pop and push may share a cycle even when full
	always_comb begin
		do_pop = pop && (lv_q != '0);
		do_push = push && ((lv_q != (AW+1)'(DEPTH)) || do_pop);
		wp_d = do_push ? wp_q + 1'b1 : wp_q;
		rp_d = do_pop ? rp_q + 1'b1 : rp_q;
		lv_d = lv_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_q <= '0;
			rp_q <= '0;
			lv_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			lv_q <= lv_d;
		end
	end

	// storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wp_q] <= din;
		end
	end

	assign dout = mem[rp_q];
	assign level = lv_q;
endmodule : sample_fifo

//--- hw/ao_timing_engine.sv
// analog_output_timing_engine: one hardware-timed output timing engine with apb registers
// Behaviour
// - single-point mode: unbuffered, sample clock or change-detect
// - late single-point write raises a warning flag
// - buffered samples pass through the onboard fifo
// - finite mode stops after programmed sample count
// - continuous modes run until stop command
// - host regeneration keeps fetching, up to 2**CH_W channels
// - onboard regeneration replays fifo, at most 16 channels
// - non-regeneration flags underflow when data runs short
// - each sample clock updates all channels together
// - sample clock routable to terminals, active high default
// - sample clock divided from selectable, unroutable timebase
// - oversample timebases 10/12.8/13.1072 MHz, fastest default
// - update rate is integer division of timebase
// - start on trigger, else on software start
// - internal clock: programmable start-to-first-sample delay
// - selectable start source with rising/falling edge
// - start trigger drives terminal as high pulse
// - time trigger fires at configured device time
// - pause blocks new samples, current one completes
// - onboard clock: resume at once on pause release
// - other clocks: resume on next clock edge
// - pause is level sensitive, selectable source and polarity
// - eight independent engines, each with own configuration
module analog_output_timing_engine import analog_output_pkg::*; #(
	parameter int W = 32,
	parameter int DEPTH = 64,
	parameter int CH_W = 5,
	parameter int ENGINE_ID = 0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [W-1:0] host_data,
	input wire logic host_valid,
	output logic host_ready,
	output logic [W-1:0] dac_data,
	output logic [CH_W-1:0] dac_chan,
	output logic dac_load,
	output logic dac_update,
	input wire logic [TERMS-1:0] programmable_function_terminal_in,
	output logic [TERMS-1:0] programmable_function_terminal_out,
	output logic [TERMS-1:0] programmable_function_terminal_oe,
	input wire logic ext_sclk,
	input wire logic ext_tb,
	input wire logic [2:0] os_tb,
	input wire logic ai_ref_trig,
	input wire logic ai_start_trig,
	input wire logic int_trig,
	input wire logic ai_cmp,
	input wire logic chg_det,
	input wire logic [31:0] dev_time,
	output logic running
);
	localparam int LW = $clog2(DEPTH) + 1;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (ENGINE_ID < 0 || ENGINE_ID >= ENGINES) begin : g_bad_id
		$error("engine index out of range");
	end
	if (W < 1 || W > 32 || CH_W < 4 || LW > 16) begin : g_bad_size
		$error("unsupported data, channel or fifo size");
	end

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	mode_t mode_q, mode_d;
	trig_t trig_q, trig_d;
	logic [31:0] div_q, div_d, count_q, count_d, delay_q, delay_d, nchan_q, nchan_d;
	logic [31:0] buflen_q, buflen_d, ttime_q, ttime_d, sp_q, sp_d, rd_v;
	logic sp_fresh_q, sp_fresh_d, under_q, under_d, late_q, late_d, cfgerr_q, cfgerr_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	eng_state_t st_q, st_d;
	logic [31:0] tbdiv_q, tbdiv_d, dcnt_q, dcnt_d, done_q, done_d;
	logic [CH_W-1:0] ch_q, ch_d, dc_d;
	logic [LW-1:0] loaded_q, loaded_d, lvl;
	logic paused_q, trg_prev_q, trg_lvl, load_d, upd_d, run_d, hr_d;
	logic [W-1:0] dd_d, fifo_dout, fifo_din;
	logic [NPINS-1:0] pin_s, pin_p_q, rise;
	logic [TERMS-1:0] po_d, oe_d;
	logic start_cmd, stop_cmd, swtrig_cmd, setup, wr_acc;
	logic ev_under, ev_late, ev_cfgerr, sp_take, pop, recirc, host_push;
	logic int_src, buffered, finite, onboard, cfg_ok, have_data, last;
	logic tb_tick, int_tick, raw_tick, tick, resume, p_act, fire, go, start_ev, sclk_ev;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// write strobe for one register, taken in the access cycle
	function automatic logic wr_to(input logic [7:0] ofs);
		return wr_acc && (paddr == ofs);
	endfunction : wr_to

	// rate of the selected timebase, zero when external
	function automatic logic [31:0] tb_hz(input logic [2:0] sel);
		case (sel)
			TB_INT: tb_hz = CLK_HZ;
			TB_10M: tb_hz = TB_10M_HZ;
			TB_12M8: tb_hz = TB_12M8_HZ;
			TB_13M1: tb_hz = TB_13M1_HZ;
			default: tb_hz = '0;
		endcase
	endfunction : tb_hz

	// ------------------------------------------------------------
	// pins, fifo
	// ------------------------------------------------------------
	pin_sync #(.W(NPINS)) u_sync (
		.clk(clk),
		.rst(rst),
		.d({os_tb, ext_tb, ext_sclk, programmable_function_terminal_in}),
		.q(pin_s)
	);

	assign rise = pin_s & ~pin_p_q;
	assign host_push = host_valid && host_ready;
	assign fifo_din = recirc ? fifo_dout : host_data;

	sample_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
		.clk(clk),
		.rst(rst),
		.push(host_push || recirc),
		.din(fifo_din),
		.pop(pop),
		.dout(fifo_dout),
		.level(lvl)
	);

	// ------------------------------------------------------------
	// apb register file
	// ------------------------------------------------------------
	// zero wait states: pready rises in the first access cycle
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pready_q && pwrite;
	// decoded in place: a continuous assign would not see the function's hidden inputs
	assign start_cmd = wr_acc && (paddr == OFS_CTRL) && pwdata[CTL_START];
	assign stop_cmd = wr_acc && (paddr == OFS_CTRL) && pwdata[CTL_STOP];
	assign swtrig_cmd = wr_acc && (paddr == OFS_CTRL) && pwdata[CTL_SWTRIG];

	// read mux and register updates; hardware sets win over clears
	always_comb begin
		mode_d = wr_to(OFS_MODE) ? mode_t'(pwdata) : mode_q;
		trig_d = wr_to(OFS_TRIG) ? trig_t'(pwdata) : trig_q;
		div_d = wr_to(OFS_DIV) ? pwdata : div_q;
		count_d = wr_to(OFS_COUNT) ? pwdata : count_q;
		delay_d = wr_to(OFS_DELAY) ? pwdata : delay_q;
		nchan_d = wr_to(OFS_NCHAN) ? pwdata : nchan_q;
		buflen_d = wr_to(OFS_BUFLEN) ? pwdata : buflen_q;
		ttime_d = wr_to(OFS_TTIME) ? pwdata : ttime_q;
		sp_d = wr_to(OFS_SPDATA) ? pwdata : sp_q;
		sp_fresh_d = wr_to(OFS_SPDATA) || (sp_fresh_q && !sp_take);
		under_d = ev_under || (under_q && !(wr_to(OFS_STATUS) && pwdata[STS_UNDER]));
		late_d = ev_late || (late_q && !(wr_to(OFS_STATUS) && pwdata[STS_LATE]));
		cfgerr_d = ev_cfgerr || (cfgerr_q && !(wr_to(OFS_STATUS) && pwdata[STS_CFGERR]));
		rd_v = '0;
		pslverr_d = 1'b0;
		case (paddr)
			OFS_CTRL: rd_v = '0;
			OFS_MODE: rd_v = mode_q;
			OFS_TRIG: rd_v = trig_q;
			OFS_DIV: rd_v = div_q;
			OFS_COUNT: rd_v = count_q;
			OFS_DELAY: rd_v = delay_q;
			OFS_NCHAN: rd_v = nchan_q;
			OFS_BUFLEN: rd_v = buflen_q;
			OFS_TTIME: rd_v = ttime_q;
			OFS_SPDATA: rd_v = sp_q;
			OFS_STATUS: begin
				rd_v[STS_LEVEL +: LW] = lvl;
				rd_v[STS_RUN] = running;
				rd_v[STS_ARMED] = (st_q == ST_ARMED);
				rd_v[STS_UNDER] = under_q;
				rd_v[STS_LATE] = late_q;
				rd_v[STS_CFGERR] = cfgerr_q;
			end
			OFS_DONE: rd_v = done_q;
			OFS_TBFREQ: rd_v = tb_hz(mode_q.tb_sel);
			default: pslverr_d = setup;
		endcase
		pready_d = setup;
		prdata_d = (setup && !pwrite) ? rd_v : '0;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_q <= mode_t'(MODE_RST);
			trig_q <= '0;
			div_q <= ONE_RST;
			count_q <= ONE_RST;
			delay_q <= '0;
			nchan_q <= ONE_RST;
			buflen_q <= ONE_RST;
			ttime_q <= '0;
			sp_q <= '0;
			sp_fresh_q <= 1'b0;
			under_q <= 1'b0;
			late_q <= 1'b0;
			cfgerr_q <= 1'b0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			mode_q <= mode_d;
			trig_q <= trig_d;
			div_q <= div_d;
			count_q <= count_d;
			delay_q <= delay_d;
			nchan_q <= nchan_d;
			buflen_q <= buflen_d;
			ttime_q <= ttime_d;
			sp_q <= sp_d;
			sp_fresh_q <= sp_fresh_d;
			under_q <= under_d;
			late_q <= late_d;
			cfgerr_q <= cfgerr_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// ------------------------------------------------------------
	// timebase, sample clock, triggers
	// ------------------------------------------------------------
	// mode decode and config check; onboard replay needs the whole buffer loaded
	always_comb begin
		buffered = !mode_q.hw_timed_single_point_mode;
		finite = buffered && (mode_q.smode == SM_FINITE);
		onboard = buffered && (mode_q.smode == SM_ONBOARD);
		int_src = !mode_q.ext_sclk && (mode_q.timing == TT_SCLK);
		have_data = 32'(lvl) >= nchan_q;
		last = (32'(ch_q) + 32'd1) == nchan_q;
		cfg_ok = (div_q != '0) && (nchan_q != '0) && (nchan_q <= 32'(2 ** CH_W));
		if (mode_q.hw_timed_single_point_mode) begin
			cfg_ok = cfg_ok && (mode_q.timing == TT_SCLK || mode_q.timing == TT_CHDET);
		end else begin
			cfg_ok = cfg_ok && (mode_q.timing == TT_SCLK);
		end
		if (onboard) begin
			cfg_ok = cfg_ok && (nchan_q <= ONBOARD_CH_LIMIT) && (buflen_q <= 32'(DEPTH))
				&& (32'(loaded_q) == buflen_q);
		end
	end

	// timebase never leaves the block; only the sample clock and the start trigger are routed
	always_comb begin
		case (mode_q.tb_sel)
			TB_INT: tb_tick = 1'b1;
			TB_EXT: tb_tick = rise[PIN_TB];
			TB_10M: tb_tick = rise[PIN_OS];
			TB_12M8: tb_tick = rise[PIN_OS + 1];
			TB_13M1: tb_tick = rise[PIN_OS + 2];
			default: tb_tick = 1'b0;
		endcase
		int_tick = tb_tick && (tbdiv_q == div_q - 32'd1);
		if (mode_q.hw_timed_single_point_mode && mode_q.timing == TT_CHDET) begin
			raw_tick = chg_det;
		end else if (mode_q.ext_sclk) begin
			raw_tick = rise[PIN_SCLK];
		end else begin
			raw_tick = int_tick;
		end
		p_act = trig_q.pause_en && ((trig_q.pause_analog ? ai_cmp : pin_s[trig_q.pause_term])
			^ trig_q.pause_low);
		resume = int_src && paused_q && !p_act;
		tick = (raw_tick && !p_act) || resume;
		case (trig_q.start_src)
			SS_TERM: trg_lvl = pin_s[trig_q.start_term];
			SS_AIREF: trg_lvl = ai_ref_trig;
			SS_AISTART: trg_lvl = ai_start_trig;
			SS_INTERNAL: trg_lvl = int_trig;
			default: trg_lvl = 1'b0;
		endcase
		case (trig_q.start_src)
			SS_SW: fire = swtrig_cmd;
			SS_TIME: fire = (dev_time == ttime_q);
			SS_NONE: fire = 1'b0;
			default: fire = trig_q.start_fall ? (trg_prev_q && !trg_lvl) : (!trg_prev_q && trg_lvl);
		endcase
		go = (st_q == ST_IDLE && start_cmd && cfg_ok && trig_q.start_src == SS_NONE)
			|| (st_q == ST_ARMED && fire);
	end

	// ------------------------------------------------------------
	// engine state machine and outputs
	// ------------------------------------------------------------
	// paused ticks are dropped; a load in progress completes unless a stop command ends it
	always_comb begin
		st_d = st_q;
		dcnt_d = dcnt_q;
		done_d = done_q;
		ch_d = ch_q;
		ev_under = 1'b0;
		ev_late = 1'b0;
		ev_cfgerr = 1'b0;
		sp_take = 1'b0;
		pop = 1'b0;
		recirc = 1'b0;
		start_ev = 1'b0;
		sclk_ev = 1'b0;
		load_d = 1'b0;
		upd_d = 1'b0;
		dd_d = dac_data;
		dc_d = dac_chan;
		if (st_q == ST_IDLE || resume) begin
			tbdiv_d = '0;
		end else if (tb_tick) begin
			tbdiv_d = int_tick ? '0 : tbdiv_q + 32'd1;
		end else begin
			tbdiv_d = tbdiv_q;
		end
		unique case (st_q)
			ST_IDLE: begin
				if (start_cmd && !cfg_ok) begin
					ev_cfgerr = 1'b1;
				end else if (start_cmd) begin
					done_d = '0;
					st_d = ST_ARMED;
				end
			end
			ST_ARMED: st_d = ST_ARMED;
			ST_DELAY: begin
				dcnt_d = dcnt_q + 32'd1;
				if (dcnt_q + 32'd1 >= delay_q) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (tick) begin
					sclk_ev = 1'b1;
					ch_d = '0;
					if (mode_q.hw_timed_single_point_mode) begin
						ev_late = !sp_fresh_q;
						sp_take = 1'b1;
						st_d = ST_LOAD;
					end else if (have_data) begin
						st_d = ST_LOAD;
					end else begin
						ev_under = (mode_q.smode == SM_NONREGEN);
					end
				end
			end
			ST_LOAD: begin
				load_d = 1'b1;
				dc_d = ch_q;
				dd_d = mode_q.hw_timed_single_point_mode ? sp_q[W-1:0] : fifo_dout;
				pop = buffered;
				recirc = onboard;
				ch_d = ch_q + 1'b1;
				if (last) begin
					upd_d = 1'b1;
					done_d = done_q + 32'd1;
					st_d = (finite && done_q + 32'd1 == count_q) ? ST_IDLE : ST_RUN;
				end
			end
		endcase
		if (go) begin
			start_ev = 1'b1;
			dcnt_d = '0;
			done_d = '0;
			st_d = (int_src && delay_q != '0) ? ST_DELAY : ST_RUN;
		end
		if (stop_cmd) begin
			st_d = ST_IDLE;
		end
		if (!onboard) begin
			loaded_d = '0;
		end else begin
			loaded_d = loaded_q + LW'(host_push);
		end
		hr_d = buffered && (32'(lvl) + 32'd2 <= 32'(DEPTH))
			&& !(onboard && 32'(loaded_d) >= buflen_q);
		for (int i = 0; i < TERMS; i++) begin
			oe_d[i] = (mode_q.sclk_route && mode_q.sclk_term == 3'(i))
				|| (trig_q.start_route && trig_q.start_oterm == 3'(i));
			po_d[i] = ((mode_q.sclk_route && mode_q.sclk_term == 3'(i)) && (sclk_ev ^ mode_q.sclk_pol))
				|| ((trig_q.start_route && trig_q.start_oterm == 3'(i)) && start_ev);
		end
		run_d = (st_d == ST_DELAY) || (st_d == ST_RUN) || (st_d == ST_LOAD);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE;
			tbdiv_q <= '0;
			dcnt_q <= '0;
			done_q <= '0;
			ch_q <= '0;
			loaded_q <= '0;
			paused_q <= 1'b0;
			trg_prev_q <= 1'b0;
			pin_p_q <= '0;
			host_ready <= 1'b0;
			dac_data <= '0;
			dac_chan <= '0;
			dac_load <= 1'b0;
			dac_update <= 1'b0;
			programmable_function_terminal_out <= '0;
			programmable_function_terminal_oe <= '0;
			running <= 1'b0;
		end else begin
			st_q <= st_d;
			tbdiv_q <= tbdiv_d;
			dcnt_q <= dcnt_d;
			done_q <= done_d;
			ch_q <= ch_d;
			loaded_q <= loaded_d;
			paused_q <= p_act;
			trg_prev_q <= trg_lvl;
			pin_p_q <= pin_s;
			host_ready <= hr_d;
			dac_data <= dd_d;
			dac_chan <= dc_d;
			dac_load <= load_d;
			dac_update <= upd_d;
			programmable_function_terminal_out <= po_d;
			programmable_function_terminal_oe <= oe_d;
			running <= run_d;
		end
	end

	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign prdata = prdata_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_last_sample;
		st_q == ST_LOAD && last && finite && (done_q + 32'd1 == count_q) && !go;
	endsequence
	sequence s_delayed_go;
		go && !stop_cmd && int_src && delay_q != '0;
	endsequence

	AST_FINITE_STOP: assert property (s_last_sample |=> st_q == ST_IDLE && !running)
		else $error("finite generation did not stop at count");
	AST_STOP_CMD: assert property (stop_cmd |=> st_q == ST_IDLE ##1 !running)
		else $error("stop command ignored");
	// an older underflow may still stand; only a fresh one would be an error here
	AST_LATE_WARN: assert property (st_q == ST_RUN && tick
		&& mode_q.hw_timed_single_point_mode && !sp_fresh_q |=> late_q && !$rose(under_q))
		else $error("late write not flagged as warning");
	AST_UNDERFLOW: assert property (ev_under && !stop_cmd |=> under_q && st_q == ST_RUN)
		else $error("underflow not latched");
	AST_UPDATE_ALL: assert property (dac_update
		|-> dac_load && 32'(dac_chan) + 32'd1 == nchan_q)
		else $error("update not on last channel load");
	AST_NO_HOST_SINGLE_POINT: assert property (
		mode_q.hw_timed_single_point_mode [*2] |-> !host_ready)
		else $error("host transfer accepted in single-point mode");
	AST_PAUSE_BLOCK: assert property (st_q == ST_RUN && p_act && !stop_cmd |=> st_q != ST_LOAD)
		else $error("sample started while paused");
	AST_RESUME_NOW: assert property (st_q == ST_RUN && resume && have_data && buffered
		&& !stop_cmd |=> st_q == ST_LOAD)
		else $error("no immediate resume on onboard clock");
	AST_START_DELAY: assert property (s_delayed_go |=> st_q == ST_DELAY [*1] ##0 dcnt_q == '0)
		else $error("start delay skipped");
	AST_START_PULSE: assert property (go && trig_q.start_route
		|=> programmable_function_terminal_oe[$past(trig_q.start_oterm)]
		&& programmable_function_terminal_out[$past(trig_q.start_oterm)]
		##1 !programmable_function_terminal_out[$past(trig_q.start_oterm, 2)])
		else $error("start trigger pulse not driven");
endmodule : analog_output_timing_engine

//--- test/host_model.sv
// host_model: host buffer feeding sample words to the engine
module host_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic host_ready,
	output logic [31:0] host_data,
	output logic host_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] seq_q;

	// -----------------------------------------------
	// word source
	// -----------------------------------------------
	// idle data is inverted so a stale word never looks valid
	assign host_data = host_valid ? seq_q : ~seq_q;
	// words leave in buffer order, one per accepted cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seq_q <= 32'h0;
			host_valid <= 1'b0;
		end else begin
			if (host_valid && host_ready) seq_q <= seq_q + 32'h1;
			host_valid <= en || (host_valid && !host_ready);
		end
	end
endmodule : host_model

//--- test/tb_analog_output_timing_engine.sv
// tb_analog_output_timing_engine: register, trigger, mode and flag tests
module tb_analog_output_timing_engine import analog_output_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, en = 0, err;
	logic [7:0] paddr = 8'h00;
	logic [7:0] programmable_function_terminal_out, programmable_function_terminal_oe;
	logic [31:0] pwdata = 32'h0, cnt = 32'h0, prdata, rd, host_data, dac_data, first_word;
	logic pready, pslverr, host_valid, host_ready, dac_load, dac_update, running;
	logic [4:0] dac_chan;
	int mismatches = 0, tests_run = 0, cyc = 0, loads = 0, updates = 0;

	analog_output_timing_engine #(.DEPTH(8)) analog_output_timing_engine_i (.clk, .rst,
		.paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .host_data,
		.host_valid, .host_ready, .dac_data, .dac_chan, .dac_load, .dac_update,
		.programmable_function_terminal_in(cnt[15:8]), .programmable_function_terminal_out,
		.programmable_function_terminal_oe, .ext_sclk(cnt[5]), .ext_tb(cnt[1]),
		.os_tb(cnt[4:2]), .ai_ref_trig(1'b0), .ai_start_trig(1'b0), .int_trig(1'b0),
		.ai_cmp(cnt[7]), .chg_det(cnt[3]), .dev_time(cnt), .running);
	host_model host_model_i (.clk, .rst, .en, .host_ready, .host_data, .host_valid);

	// -----------------------------------------------
	// clock, free counter, watchdog, output monitor
	// -----------------------------------------------
	initial forever #4 clk = ~clk;
	always @(posedge clk) begin
		cnt <= cnt + 32'h1;
		cyc++;
		if (cyc > 20000) begin
			mismatches++;
			conclude();
		end
		if (dac_load === 1'b1) begin
			if (loads == 0) first_word = dac_data;
			loads++;
			if (dac_update === 1'b1) begin
				updates++;
				check(32'(dac_chan), 32'h1);
			end
		end
	end

	// -----------------------------------------------
	// tasks
	// -----------------------------------------------
	// one apb transfer; holds the request until pready is sampled
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	// bounded wait for a run to start and end
	task run_out;
		for (int i = 0; i < 40 && running !== 1'b1; i++) @(posedge clk);
		for (int i = 0; i < 600 && running !== 1'b0; i++) @(posedge clk);
		// one more edge so the monitor has counted the last word
		@(posedge clk);
	endtask : run_out
	task conclude;
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : conclude

	// -----------------------------------------------
	// main sequence
	// -----------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		apb(0, OFS_MODE, 0);
		check(rd, MODE_RST);
		apb(0, OFS_DIV, 0);
		check(rd, ONE_RST);
		apb(0, 8'h3c, 0);
		check(32'(err), 32'h1);
		en <= 1;
		apb(1, OFS_COUNT, 3);
		apb(1, OFS_NCHAN, 2);
		apb(1, OFS_DIV, 4);
		apb(1, OFS_TRIG, {29'h0, SS_SW});
		apb(1, OFS_CTRL, 1);
		apb(0, OFS_STATUS, 0);
		check(32'(rd[STS_ARMED]), 32'h1);
		check(32'(updates), 32'h0);
		apb(1, OFS_CTRL, 4);
		run_out();
		check(32'(updates), 32'h3);
		check(32'(loads), 32'h6);
		check(first_word, 32'h0);
		// starve the host so non-regeneration runs dry
		en <= 0;
		apb(1, OFS_TRIG, 0);
		apb(1, OFS_MODE, {30'h0, SM_NONREGEN});
		apb(1, OFS_CTRL, 1);
		repeat (200) @(posedge clk);
		apb(0, OFS_STATUS, 0);
		check(32'(rd[STS_UNDER]), 32'h1);
		apb(1, OFS_CTRL, 2);
		// single-point regen, paused while the analog level is high, goes late
		apb(1, OFS_TRIG, 32'h8800);
		apb(1, OFS_MODE, 32'h2005);
		apb(1, OFS_CTRL, 1);
		repeat (300) @(posedge clk);
		check(32'(programmable_function_terminal_oe), 32'h1);
		apb(1, OFS_CTRL, 2);
		apb(0, OFS_STATUS, 0);
		check(32'(rd[STS_LATE]), 32'h1);
		check(32'(rd[STS_UNDER]), 32'h1);
		apb(1, OFS_STATUS, 32'h0c);
		apb(0, OFS_STATUS, 0);
		check(32'(rd[3:2]), 32'h0);
		conclude();
	end
endmodule : tb_analog_output_timing_engine
